// ### scc_top.sv
`timescale 1ns/10ps
module scc_top
  import scc_pkg::*;
(
  // Clock and reset
  input  wire logic        CLK_SYS_I,
  input  wire logic        RST_N_I,
  // Wishbone slave
  input  wire logic        WB_CYC_I,
  input  wire logic        WB_STB_I,
  input  wire logic        WB_WE_I,
  input  wire logic [4:0]  WB_ADR_I,
  input  wire logic [3:0]  WB_SEL_I,
  input  wire logic [31:0] WB_DAT_I,
  output logic      [31:0] WB_DAT_O,
  output logic             WB_ACK_O,
  // Global interrupt enable from the cpu status register
  input  wire logic        GLOBAL_IE_I,
  // External trigger sources, one per trigger code 1..7; bit 0 unused, code zero follows completion
  input  wire logic [7:0]  TRIG_SRC_I,
  // Analog core
  input  wire logic [9:0]  CORE_RESULT_I,
  output logic             CORE_POWER_O,
  output logic             CORE_REFSEL_O,
  output logic      [2:0]  CORE_CHANNEL_O,
  output logic             CORE_SAMPLE_O,
  // Interrupt request
  output logic             IRQ_O
);

  typedef struct packed {
    logic [7:0]  insel;
    logic [7:0]  ctla;
    logic [7:0]  ctlb;
    logic [7:0]  pwr;
    logic [9:0]  result;
    logic        locked;
    logic        ack;
    logic [31:0] rdat;
    logic [7:0]  trig_s1;
    logic [7:0]  trig_s2;
    logic        trig_prev;
    logic        done_p;
    logic [6:0]  presc;
    logic [4:0]  cnt;
    logic        first;
    logic        refsel;
    logic [2:0]  chan;
    logic        sample;
    scc_state_e  state;
  } scc_s;

  scc_s st_ff;
  scc_s nxt_st;

  // Prescaler tick for division 2..128
  function automatic logic presc_tick(input logic [2:0] ps,
                                      input logic [6:0] cnt);
    logic [6:0] mask;
    mask = (ps == 3'h0) ? 7'h01 : 7'((8'h1 << ps) - 8'h1);
    presc_tick = ((cnt & mask) == mask);
  endfunction : presc_tick

  // Address match for one register
  function automatic logic adr_hit(input logic [4:0] adr,
                                   input logic [4:0] ofs);
    adr_hit = (adr == ofs);
  endfunction : adr_hit

  // Low result byte under the alignment choice
  function automatic logic [7:0] res_lo(input logic [9:0] r,
                                        input logic       ladj);
    res_lo = ladj ? {r[1:0], 6'h00} : r[7:0];
  endfunction : res_lo

  // High result byte under the alignment choice
  function automatic logic [7:0] res_hi(input logic [9:0] r,
                                        input logic       ladj);
    res_hi = ladj ? r[9:2] : {6'h00, r[9:8]};
  endfunction : res_hi

  // Control A write: start kept, done flag cleared by a one
  function automatic logic [7:0] ctla_wr(input logic [7:0] old,
                                         input logic [7:0] d);
    logic [7:0] v;
    v = (d & 8'hbf) | (old & 8'h40);
    v[SCC_B_DONE] = old[SCC_B_DONE] & ~d[SCC_B_DONE];
    ctla_wr = v;
  endfunction : ctla_wr

  // Trigger level; code zero follows the completion pulse
  function automatic logic trig_pick(input logic [2:0] ts,
                                     input logic       done_ev,
                                     input logic [7:0] pins);
    trig_pick = (ts == SCC_TS_FREE) ? done_ev : pins[ts];
  endfunction : trig_pick

  logic       bus_req;
  logic       wr_lane;
  logic       rd_lane;
  logic       hit_reslo;
  logic       hit_reshi;
  logic       ladj;
  logic       trig_lvl;
  logic       trig_edge;
  logic       tick;
  logic       en;
  logic       ate;
  logic [2:0] tsrc;

  assign bus_req   = WB_CYC_I & WB_STB_I & ~st_ff.ack;
  assign wr_lane   = bus_req & WB_WE_I & WB_SEL_I[0];
  // Result byte reads drive the lock
  assign rd_lane   = bus_req & ~WB_WE_I & WB_SEL_I[0];
  assign hit_reslo = adr_hit(WB_ADR_I, SCC_OFS_RESLO);
  assign hit_reshi = adr_hit(WB_ADR_I, SCC_OFS_RESHI);
  assign ladj      = st_ff.ctlb[SCC_B_LADJ];
  assign en        = st_ff.ctla[SCC_B_EN];
  assign ate       = st_ff.ctla[SCC_B_ATE];
  assign tsrc      = st_ff.ctlb[SCC_B_TSLO +: 3];
  // Free mode triggers on each completion, not on the flag level
  assign trig_lvl  = trig_pick(tsrc, st_ff.done_p, st_ff.trig_s2); // R18
  assign trig_edge = trig_lvl & ~st_ff.trig_prev;
  assign tick      = presc_tick(st_ff.ctla[SCC_B_PSLO +: 3], st_ff.presc);

  // Next state
  always_comb begin
    logic       start_req;
    logic       done;
    logic [7:0] wd;
    start_req = 1'b0;
    done      = 1'b0;
    wd        = WB_DAT_I[7:0];
    nxt_st    = st_ff;
    nxt_st.ack    = bus_req;
    nxt_st.sample = 1'b0;
    nxt_st.done_p = 1'b0;
    // Pins from other sources pass two flops
    nxt_st.trig_s1   = TRIG_SRC_I;
    nxt_st.trig_s2   = st_ff.trig_s1;
    nxt_st.trig_prev = trig_lvl;

    // Register writes
    if (wr_lane) begin
      case (WB_ADR_I)
        5'(SCC_OFS_INSEL): begin
          nxt_st.insel = wd & 8'h47;
        end
        5'(SCC_OFS_CTLA): begin
          // Start bit only settable, flag cleared by writing one
          nxt_st.ctla = ctla_wr(st_ff.ctla, wd);
          if (wd[SCC_B_START] && wd[SCC_B_EN]) begin
            start_req = 1'b1; // R11 R19
          end
          if (!wd[SCC_B_EN]) begin
            nxt_st.first = 1'b1;
          end
        end
        5'(SCC_OFS_CTLB): begin
          nxt_st.ctlb = wd & 8'h17;
        end
        SCC_OFS_PWR: begin
          nxt_st.pwr = wd & 8'h01;
        end
        default: begin
        end
      endcase
    end

    // Result lock on low read, release on high read
    if (rd_lane) begin
      if (hit_reslo) begin
        nxt_st.locked = 1'b1; // R7
      end else if (hit_reshi) begin
        nxt_st.locked = 1'b0; // R8
      end
    end

    // Read data
    case (WB_ADR_I)
      5'(SCC_OFS_INSEL): nxt_st.rdat = {24'h0, st_ff.insel};
      // Start reads one while any conversion runs
      5'(SCC_OFS_CTLA):  nxt_st.rdat = {24'h0, st_ff.ctla}; // R20
      5'(SCC_OFS_CTLB):  nxt_st.rdat = {24'h0, st_ff.ctlb};
      5'(SCC_OFS_RESLO): nxt_st.rdat = {24'h0,
                           res_lo(st_ff.result, ladj)}; // R6
      SCC_OFS_RESHI:     nxt_st.rdat = {24'h0,
                           res_hi(st_ff.result, ladj)}; // R6
      SCC_OFS_PWR:       nxt_st.rdat = {24'h0, st_ff.pwr};
      default:           nxt_st.rdat = 32'h0;
    endcase

    // Prescaler, held in reset while disabled
    if (!en) begin
      nxt_st.presc = 7'h00; // R23
    end else begin
      nxt_st.presc = 7'(st_ff.presc + 7'h01); // R23
    end

    // Auto trigger edge, ignored while busy
    if (en && ate && trig_edge && st_ff.state == SCC_IDLE) begin // R13 R15 R16
      nxt_st.presc = 7'h00; // R14
      start_req    = 1'b1;  // R14 R18
    end

    // Mux selection follows registers only while enabled and not in SCC_CONV (idle or waiting)
    if (en && st_ff.state != SCC_CONV) begin // R5 R12
      nxt_st.refsel = st_ff.insel[SCC_B_REFSEL]; // R3
      nxt_st.chan   = st_ff.insel[SCC_B_MUXLO +: 3]; // R2 R4
    end

    // Converter sequence
    case (st_ff.state)
      SCC_IDLE: begin
        if (start_req) begin
          nxt_st.ctla[SCC_B_START] = 1'b1; // R20
          nxt_st.state = SCC_WAIT;
        end
      end
      SCC_WAIT: begin
        // Begin at next converter clock
        if (tick) begin
          nxt_st.cnt   = st_ff.first ? SCC_CYC_FIRST : SCC_CYC_NORMAL; // R21
          nxt_st.first = 1'b0;
          nxt_st.state = SCC_CONV;
        end
      end
      SCC_CONV: begin
        if (tick) begin
          nxt_st.cnt = 5'(st_ff.cnt - 5'h01);
          if (st_ff.cnt == 5'h02) begin
            nxt_st.sample = 1'b1;
          end
          if (st_ff.cnt == 5'h01) begin
            done = 1'b1;
          end
        end
      end
      default: begin
        nxt_st.state = SCC_IDLE;
      end
    endcase

    // Completion: flag sets even when result dropped; set beats clear
    if (done) begin
      nxt_st.ctla[SCC_B_DONE]  = 1'b1; // R22 R9
      nxt_st.done_p = 1'b1; // R18
      nxt_st.ctla[SCC_B_START] = 1'b0; // R11 R22
      nxt_st.state = SCC_IDLE;
      if (!nxt_st.locked) begin
        nxt_st.result = CORE_RESULT_I; // R1 R7 R22
      end
    end

    // Disable aborts any conversion
    if (!nxt_st.ctla[SCC_B_EN]) begin
      nxt_st.state = SCC_IDLE;
      nxt_st.ctla[SCC_B_START] = 1'b0;
      nxt_st.first = 1'b1;
      nxt_st.sample = 1'b0;
    end
  end

  // State register
  always_ff @(posedge CLK_SYS_I) begin
    if (!RST_N_I) begin
      st_ff        <= '0;
      st_ff.pwr    <= SCC_RST_PWR;
      st_ff.first  <= 1'b1;
      st_ff.state  <= SCC_IDLE;
    end else begin
      st_ff <= nxt_st;
    end
  end

  // Outputs
  assign WB_DAT_O       = st_ff.rdat;
  assign WB_ACK_O       = st_ff.ack;
  // Core powered only when enabled and not in power reduction
  assign CORE_POWER_O   = st_ff.ctla[SCC_B_EN] & ~st_ff.pwr[SCC_B_PRED]; // R10
  assign CORE_REFSEL_O  = st_ff.refsel;
  assign CORE_CHANNEL_O = st_ff.chan;
  assign CORE_SAMPLE_O  = st_ff.sample;
  assign IRQ_O = st_ff.ctla[SCC_B_DONE] & st_ff.ctla[SCC_B_IE]
               & GLOBAL_IE_I; // R24

endmodule : scc_top

// ### scc_pkg.sv
// Function
// R1 - Each conversion yields a 10-bit code, zero at ground, full at reference.
// R2 - Eight single-ended inputs: four pins, temperature, reference, battery, ground.
// R3 - reference_select picks main supply or internal 1.1V reference.
// R4 - 3-bit channel_select picks the input; 111 selects the temperature sensor.
// R5 - Reference and channel reach the converter only while converter_enable is set.
// R6 - Result right-aligned by default, left-aligned when left_adjust_select is set.
// R7 - Reading low byte locks result; completions before high byte read are dropped.
// R8 - Reading high byte unlocks result updates.
// R9 - Done flag still sets when a finished result is dropped.
// R10 - Software clears converter_power_reduction before using the converter.
// R11 - Writing conversion_start begins one conversion; hardware clears it at end.
// R12 - A channel change during conversion takes effect after that conversion.
// R13 - auto_trigger_enable lets the selected trigger source start conversions.
// R14 - A trigger rising edge resets the prescaler and starts a conversion.
// R15 - A trigger still high at completion starts nothing; only fresh edges.
// R16 - Trigger rising edges during a conversion are ignored.
// R17 - Software clears a flag used as trigger before its next event.
// R18 - With done flag as trigger, conversions run continuously after first start.
// R19 - With auto trigger on, writing conversion_start still starts one conversion.
// R20 - conversion_start reads one during every conversion.
// R21 - Normal conversion lasts 13 converter clocks, first after enable 25.
// R22 - At completion write result, set done flag, clear conversion_start.
// R23 - Prescaler runs while converter_enable set, held reset while clear.
// R24 - Interrupt request when done flag, its enable and global enable set.
package scc_pkg;
  // Register byte offsets
  localparam logic [4:0] SCC_OFS_INSEL  = 5'h00; // input_select_register
  localparam logic [4:0] SCC_OFS_CTLA   = 5'h04; // converter_control_a
  localparam logic [4:0] SCC_OFS_CTLB   = 5'h08; // converter_control_b
  localparam logic [4:0] SCC_OFS_RESLO  = 5'h0c; // result_low_byte
  localparam logic [4:0] SCC_OFS_RESHI  = 5'h10; // result_high_byte
  localparam logic [4:0] SCC_OFS_PWR    = 5'h14; // power_reduction_register
  // input_select_register fields
  localparam int SCC_B_REFSEL = 6;
  localparam int SCC_B_MUXLO  = 0;
  // converter_control_a fields
  localparam int SCC_B_EN    = 7;
  localparam int SCC_B_START = 6;
  localparam int SCC_B_ATE   = 5;
  localparam int SCC_B_DONE  = 4;
  localparam int SCC_B_IE    = 3;
  localparam int SCC_B_PSLO  = 0;
  // converter_control_b fields
  localparam int SCC_B_LADJ  = 4;
  localparam int SCC_B_TSLO  = 0;
  // power_reduction_register field
  localparam int SCC_B_PRED  = 0;
  // Reset values
  localparam logic [7:0] SCC_RST_REG  = 8'h00;
  localparam logic [7:0] SCC_RST_PWR  = 8'h01;
  // Conversion timing in converter clocks
  localparam logic [4:0] SCC_CYC_NORMAL = 5'd13;
  localparam logic [4:0] SCC_CYC_FIRST  = 5'd25;
  // Trigger source codes
  localparam logic [2:0] SCC_TS_FREE = 3'h0;
  localparam logic [2:0] SCC_TS_TRIG = 3'h7;
  // Channel code of temperature sensor
  localparam logic [2:0] SCC_CH_TEMP = 3'h7;
  // Converter state
  typedef enum logic [1:0] {
    SCC_IDLE = 2'b00,
    SCC_WAIT = 2'b01,
    SCC_CONV = 2'b11
  } scc_state_e;
endpackage : scc_pkg

// ### scc_core_model.sv
`timescale 1ns/10ps
module scc_core_model (
  // Clock and core controls
  input  wire logic       clk_i,
  input  wire logic       sample_i,
  input  wire logic       refsel_i,
  input  wire logic [2:0] channel_i,
  // Converted code
  output logic      [9:0] result_o
);
  logic       held_ff = 1'b0;
  logic [9:0] code_ff = 10'h155;
  // Code taken at the sample pulse; churns until the first one
  always @(posedge clk_i) begin
    if (sample_i) begin
      code_ff <= {channel_i, refsel_i, 6'h2d};
      held_ff <= 1'b1;
    end else if (!held_ff) begin
      code_ff <= ~code_ff;
    end
  end
  assign result_o = code_ff;
endmodule : scc_core_model

// ### scc_assertions.sv
`timescale 1ns/10ps
module scc_checker (
  // Clock, reset and bus
  input wire logic        CLK_SYS_I,
  input wire logic        RST_N_I,
  input wire logic        WB_CYC_I,
  input wire logic        WB_STB_I,
  input wire logic        WB_WE_I,
  input wire logic [4:0]  WB_ADR_I,
  input wire logic [31:0] WB_DAT_O,
  input wire logic        WB_ACK_O,
  // Core and interrupt
  input wire logic        GLOBAL_IE_I,
  input wire logic        CORE_POWER_O,
  input wire logic        CORE_SAMPLE_O,
  input wire logic        IRQ_O
);
  default clocking @(posedge CLK_SYS_I); endclocking
  default disable iff (!RST_N_I);
  // Bus handshake and read data
  a_ack_timing: assert property (WB_CYC_I && WB_STB_I && !WB_ACK_O |=> WB_ACK_O)
    else $error("ack not one cycle after request");
  a_ack_pulse: assert property (WB_ACK_O |=> !WB_ACK_O)
    else $error("ack longer than one cycle");
  a_ack_cause: assert property (WB_ACK_O |-> $past(WB_CYC_I) && $past(WB_STB_I))
    else $error("ack without request");
  a_rdata_upper: assert property (WB_ACK_O |-> WB_DAT_O[31:8] == 24'h0)
    else $error("upper read data not zero");
  a_unmapped_read: assert property (WB_ACK_O && !WB_WE_I && WB_ADR_I > 5'h14
    |-> WB_DAT_O == 32'h0) else $error("unmapped read not zero");
  // Conversion and interrupt
  a_sample_gap: assert property (CORE_SAMPLE_O |=> !CORE_SAMPLE_O [*8])
    else $error("samples too close");
  a_sample_power: assert property (CORE_SAMPLE_O |-> CORE_POWER_O)
    else $error("sample while unpowered");
  a_irq_gated: assert property (!GLOBAL_IE_I && !$past(GLOBAL_IE_I) |-> !IRQ_O)
    else $error("irq without global enable");
  a_reset_quiet: assert property (disable iff (1'b0)
    !RST_N_I |=> !WB_ACK_O && !CORE_SAMPLE_O && !IRQ_O)
    else $error("outputs active after reset");
endmodule : scc_checker
bind scc_top scc_checker u_chk (.CLK_SYS_I(CLK_SYS_I), .RST_N_I(RST_N_I),
  .WB_CYC_I(WB_CYC_I), .WB_STB_I(WB_STB_I), .WB_WE_I(WB_WE_I),
  .WB_ADR_I(WB_ADR_I), .WB_DAT_O(WB_DAT_O), .WB_ACK_O(WB_ACK_O),
  .GLOBAL_IE_I(GLOBAL_IE_I), .CORE_POWER_O(CORE_POWER_O),
  .CORE_SAMPLE_O(CORE_SAMPLE_O), .IRQ_O(IRQ_O));

// ### sar_converter_control_tb_top.sv
`timescale 1ns/10ps
module sar_converter_control_tb_top;
  import scc_pkg::*;
  logic        clk, rst_n, cyc, stb, we, gie, ack, pwr, reference_select, smp, irq;
  logic [3:0]  sel;
  logic [4:0]  adr;
  logic [7:0]  trig;
  logic [31:0] wdat, rdat, dato;
  logic [2:0]  chan;
  logic [9:0]  core;
  logic [16:0] lfsr;
  logic [15:0] e16;
  int          miscompares = 0, tests_run = 0, cycles = 0;
  // Device under test and analog core
  scc_top dut (.CLK_SYS_I(clk), .RST_N_I(rst_n), .WB_CYC_I(cyc),
    .WB_STB_I(stb), .WB_WE_I(we), .WB_ADR_I(adr), .WB_SEL_I(sel),
    .WB_DAT_I(wdat), .WB_DAT_O(dato), .WB_ACK_O(ack), .GLOBAL_IE_I(gie),
    .TRIG_SRC_I(trig), .CORE_RESULT_I(core), .CORE_POWER_O(pwr),
    .CORE_REFSEL_O(reference_select), .CORE_CHANNEL_O(chan), .CORE_SAMPLE_O(smp),
    .IRQ_O(irq));
  scc_core_model core_m (.clk_i(clk), .sample_i(smp), .refsel_i(reference_select),
    .channel_i(chan), .result_o(core));
  // Clock and hang guard
  initial begin
    clk = 1'b0;
    forever #2.5 clk = ~clk;
  end
  always @(posedge clk) begin
    cycles <= cycles + 1;
    if (cycles == 30000) begin
      miscompares++;
      summarize();
    end
  end
  // Expected code and its byte layout
  function automatic logic [16:0] nxt(input logic [16:0] s);
    return {s[15:0], s[16] ^ s[13]};
  endfunction : nxt
  function automatic logic [9:0] code(input logic [2:0] c, input logic r);
    return {c, r, 6'h2d};
  endfunction : code
  function automatic logic [15:0] align(input logic [9:0] v, input logic l);
    return l ? {v, 6'h00} : {6'h00, v};
  endfunction : align
  task automatic chk(input string nm, input logic [15:0] s, e);
    tests_run++;
    if (s !== e) begin
      miscompares++;
      $display("Error %s expected %h seen %h", nm, e, s);
    end
  endtask : chk
  // One classic Wishbone cycle
  task automatic bus(input logic w, input logic [4:0] a, input logic [7:0] d);
    @(posedge clk);
    cyc <= 1'b1;
    stb <= 1'b1;
    we <= w;
    adr <= a;
    wdat <= {24'h0, d};
    do @(posedge clk); while (ack !== 1'b1);
    rdat = dato;
    cyc <= 1'b0;
    stb <= 1'b0;
  endtask : bus
  task automatic wt();
    do bus(1'b0, SCC_OFS_CTLA, 8'h00); while (rdat[SCC_B_START] === 1'b1);
    chk("done", 16'(rdat[SCC_B_DONE]), 16'h1);
  endtask : wt
  // Start, move the channel mid-run, wait for the end
  task automatic conv(input logic [7:0] v, nsel);
    bus(1'b1, SCC_OFS_CTLA, v | 8'h10);
    bus(1'b1, SCC_OFS_INSEL, nsel);
    bus(1'b0, SCC_OFS_CTLA, 8'h00);
    chk("busy", 16'(rdat[SCC_B_START]), 16'h1);
    wt();
  endtask : conv
  task automatic res(input logic [9:0] e, input logic l);
    logic [7:0] lo;
    bus(1'b0, SCC_OFS_RESLO, 8'h00);
    lo = rdat[7:0];
    bus(1'b0, SCC_OFS_RESHI, 8'h00);
    chk("result", {rdat[7:0], lo}, align(e, l));
  endtask : res
  task automatic summarize();
    $display("Comparisons %0d mismatches %0d", tests_run, miscompares);
    if (miscompares == 0 && tests_run > 0)
      $display("ALL CHECKS OK");
    else
      $display("CHECKS NOT OK");
    $finish;
  endtask : summarize
  // Main sequence
  initial begin
    {rst_n, cyc, stb, we, gie} = 5'h00;
    {adr, trig, wdat, sel} = {5'h00, 8'h00, 32'h0, 4'h1};
    lfsr = 17'd88026;
    repeat (2) @(posedge clk);
    rst_n <= 1'b1;
    bus(1'b0, SCC_OFS_PWR, 8'h00);
    chk("pwr_rst", 16'(rdat[7:0]), 16'(SCC_RST_PWR));
    bus(1'b0, 5'h18, 8'h00);
    chk("unmapped", rdat[15:0], 16'h0);
    bus(1'b1, SCC_OFS_INSEL, 8'h47);
    chk("sel_off", 16'({reference_select, chan}), 16'h0);
    bus(1'b1, SCC_OFS_PWR, 8'h00);
    bus(1'b1, SCC_OFS_CTLA, 8'h80);
    @(posedge clk);
    chk("sel_on", 16'({pwr, reference_select, chan}), 16'h1f);
    conv(8'hc0, 8'h47);
    res(code(3'h7, 1'b1), 1'b0);
    // Low read locks; the next result is dropped
    bus(1'b0, SCC_OFS_RESLO, 8'h00);
    conv(8'hc0, 8'h02);
    res(code(3'h7, 1'b1), 1'b0);
    bus(1'b1, SCC_OFS_CTLA, 8'h88);
    gie <= 1'b1;
    bus(1'b0, SCC_OFS_CTLA, 8'h00);
    chk("irq", 16'(irq), 16'h1);
    gie <= 1'b0;
    bus(1'b0, SCC_OFS_CTLA, 8'h00);
    chk("irq_off", 16'(irq), 16'h0);
    for (int i = 0; i < 6; i++) begin
      lfsr = nxt(lfsr);
      bus(1'b1, SCC_OFS_CTLB, {3'h0, i[0], 4'h0});
      bus(1'b1, SCC_OFS_INSEL, {1'b0, lfsr[3], 3'h0, lfsr[2:0]});
      conv(8'hc0, {1'b0, ~lfsr[3], 3'h0, ~lfsr[2:0]});
      res(code(lfsr[2:0], lfsr[3]), i[0]);
    end
    // Trigger edge, then a level that must not restart
    bus(1'b1, SCC_OFS_INSEL, 8'h47);
    bus(1'b1, SCC_OFS_CTLB, {5'h00, SCC_TS_TRIG});
    bus(1'b1, SCC_OFS_CTLA, {5'h16, lfsr[6:4]});
    trig <= 8'h80;
    repeat (8) @(posedge clk);
    trig <= 8'h00;
    repeat (4) @(posedge clk);
    trig <= 8'h80;
    wt();
    bus(1'b1, SCC_OFS_CTLA, 8'hb0);
    repeat (100) @(posedge clk);
    bus(1'b0, SCC_OFS_CTLA, 8'h00);
    chk("no_retrig", 16'(rdat[7:0]), 16'ha0);
    conv(8'he0, 8'h47);
    res(code(3'h7, 1'b1), 1'b0);
    // Free running on the done flag
    bus(1'b1, SCC_OFS_CTLB, {5'h00, SCC_TS_FREE});
    bus(1'b1, SCC_OFS_CTLA, 8'hf0);
    repeat (3) @(posedge smp);
    bus(1'b0, SCC_OFS_CTLA, 8'h00);
    chk("free_run", 16'(rdat[7:4]), 16'hf);
    bus(1'b1, SCC_OFS_CTLA, 8'h00);
    chk("power_off", 16'(pwr), 16'h0);
    summarize();
  end
endmodule : sar_converter_control_tb_top
